// [pdm_pkg.sv]
/*
 * Shared constants and types for the program and data memory addressing
 * core: widths, reset values and the instruction command encoding.
 * Assumes a decoder on the same clock issues one command per cycle.
 */
`default_nettype none

package pdm_pkg;

    localparam int ROM_WORDS = 1024;
    localparam int PTR_W = 10;
    localparam int WORD_W = 8;
    localparam int NIB_W = 4;
    localparam int ADDR_W = 6;
    localparam int PAGE_LSB = 6;
    localparam int BLOCK_LSB = 8;
    localparam int ROW_LSB = 4;
    localparam int RAM_DIGITS = 64;
    localparam int STACK_DEPTH = 3;
    localparam int LATCH_W = 8;

    localparam logic [PTR_W-1:0] PTR_RESET = 10'h000;
    localparam logic [PTR_W-1:0] PTR_ONE = 10'h001;
    localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
    localparam logic [ADDR_W-1:0] INDEX_RESET = 6'h00;
    localparam logic [LATCH_W-1:0] LATCH_RESET = 8'h00;
    localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;

    typedef enum logic [4:0] {
        PDM_OP_NEXT = 5'h00,
        PDM_OP_JUMP = 5'h01,
        PDM_OP_CALL = 5'h02,
        PDM_OP_RETURN = 5'h03,
        PDM_OP_PAGE_JUMP = 5'h04,
        PDM_OP_PAGE_CALL = 5'h05,
        PDM_OP_INDIRECT_JUMP = 5'h06,
        PDM_OP_TABLE_LOOKUP = 5'h07,
        PDM_OP_LOAD_M = 5'h08,
        PDM_OP_STORE_M = 5'h09,
        PDM_OP_EXCH_M = 5'h0A,
        PDM_OP_DIRECT_LOAD = 5'h0B,
        PDM_OP_DIRECT_EXCH = 5'h0C,
        PDM_OP_LATCH_TO_M = 5'h0D,
        PDM_OP_M_TO_LATCH = 5'h0E,
        PDM_OP_PORT_TO_M = 5'h0F,
        PDM_OP_A_TO_ROW = 5'h10,
        PDM_OP_A_TO_DIGIT = 5'h11,
        PDM_OP_A_TO_LATCH = 5'h12,
        PDM_OP_LATCH_TO_A = 5'h13,
        PDM_OP_PORT_TO_A = 5'h14,
        PDM_OP_EXCH_SHIFT = 5'h15
    } pdm_op_t;

endpackage : pdm_pkg

`default_nettype wire

// [pdm_return_stack.sv]
/*
 * Three-level last-in first-out return address stack.
 * Assumes push and pop are never both high; push wins if they are.
 */
`timescale 1ns/1ps
`default_nettype none

module pdm_return_stack
    import pdm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic push,
    input wire logic pop,
    input wire logic [PTR_W-1:0] push_value,
    output logic [PTR_W-1:0] top
);

    typedef struct packed {
        logic [STACK_DEPTH-1:0][PTR_W-1:0] level;
    } pdm_stack_state_t;

    pdm_stack_state_t state;
    pdm_stack_state_t next_state;

    always_comb
    begin
        next_state = state;
        if (push)
        begin
            // Oldest entry falls off the bottom on overflow
            next_state.level[2] = state.level[1];
            next_state.level[1] = state.level[0];
            next_state.level[0] = push_value;
        end
        else if (pop)
        begin
            next_state.level[0] = state.level[1];
            next_state.level[1] = state.level[2];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            state <= '0;
        else
            state <= next_state;
    end

    assign top = state.level[0];

endmodule : pdm_return_stack

`default_nettype wire

// [pdm_core.sv]
/*
 * Program and data memory addressing core of a 4-bit controller:
 * program store, instruction pointer, return stack, nibble RAM,
 * accumulator paths to RAM, output latches, port and serial shifter.
 * Assumes a decoder on core_clk presents one command per instruction
 * cycle with cmd_valid; the port pins are asynchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Program store holds 1024 eight-bit words
// - Page jumps use 16 pages of 64
// - Indirect and lookup use four-page blocks
// - 10-bit pointer selects each fetched word
// - Pointer advances by one before execution
// - Control transfers load the computed target
// - Increment carries into next page
// - Three-level return stack of 10-bit addresses
// - RAM is four registers of sixteen digits
// - Index: two row bits, four digit bits
// - Addressed digit moves to A, latches; port loads it
// - Direct load/exchange use operand address
// - Digit field drives nibble outputs
// - Accumulator is main data source and sink
// - Accumulator feeds index, latches, shifter; port loads it
// - Reset clears pointer, A, index, outputs
module pdm_core
    import pdm_pkg::*;
#(
    parameter logic [WORD_W-1:0] ROM_IMAGE [ROM_WORDS] = '{default: 8'h00}
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire pdm_op_t cmd_op,
    input wire logic [PTR_W-1:0] cmd_operand,
    input wire logic [LATCH_W-1:0] port_in,
    input wire logic [NIB_W-1:0] shifter_in,
    output logic [PTR_W-1:0] instr_pointer,
    output logic [WORD_W-1:0] fetched_word,
    output logic [NIB_W-1:0] accumulator,
    output logic [ADDR_W-1:0] ram_index,
    output logic [NIB_W-1:0] nibble_out,
    output logic [LATCH_W-1:0] latch_out,
    output logic [NIB_W-1:0] shifter_out,
    output logic shifter_load
);

    typedef struct packed {
        logic [PTR_W-1:0] ptr;
        logic [WORD_W-1:0] word;
        logic [NIB_W-1:0] acc;
        logic [1:0] ram_row_field;
        logic [NIB_W-1:0] digit_select_field;
        logic [NIB_W-1:0] digit_out;
        logic [LATCH_W-1:0] latch;
        logic [NIB_W-1:0] shift_word;
        logic shift_load;
        logic [LATCH_W-1:0] port_meta;
        logic [LATCH_W-1:0] port_sync;
        logic [RAM_DIGITS-1:0][NIB_W-1:0] ram;
    } pdm_state_t;

    pdm_state_t state;
    pdm_state_t next_state;

    logic stack_push;
    logic stack_pop;
    logic [PTR_W-1:0] stack_top;
    logic [PTR_W-1:0] ptr_inc;
    logic [ADDR_W-1:0] cur_addr;
    logic [ADDR_W-1:0] direct_addr;
    logic [NIB_W-1:0] cur_digit;
    logic [NIB_W-1:0] direct_digit;
    logic [PTR_W-1:0] table_addr;
    logic [WORD_W-1:0] table_word;
    logic [NIB_W-1:0] port_nib;
    logic [NIB_W-1:0] latch_nib;
    logic hi_sel;

    // ******************************************************************
    // Address arithmetic
    // ******************************************************************
    assign ptr_inc = state.ptr + PTR_ONE;
    assign cur_addr = {state.ram_row_field, state.digit_select_field};
    assign direct_addr = cmd_operand[ADDR_W-1:0];
    assign cur_digit = state.ram[cur_addr];
    assign direct_digit = state.ram[direct_addr];
    // Block taken from the already incremented pointer
    assign table_addr = {ptr_inc[PTR_W-1:BLOCK_LSB], state.acc,
                         cur_digit};
    assign table_word = ROM_IMAGE[table_addr];
    assign hi_sel = cmd_operand[0];
    assign port_nib = hi_sel ? state.port_sync[LATCH_W-1:NIB_W]
                             : state.port_sync[NIB_W-1:0];
    assign latch_nib = hi_sel ? state.latch[LATCH_W-1:NIB_W]
                              : state.latch[NIB_W-1:0];

    assign stack_push = cmd_valid && (cmd_op == PDM_OP_CALL
                        || cmd_op == PDM_OP_PAGE_CALL);
    assign stack_pop = cmd_valid && cmd_op == PDM_OP_RETURN;

    pdm_return_stack u_stack (
        .core_clk(core_clk),
        .rst(rst),
        .push(stack_push),
        .pop(stack_pop),
        .push_value(ptr_inc),
        .top(stack_top)
    );

    // ******************************************************************
    // Next-state logic
    // ******************************************************************
    always_comb
    begin
        next_state = state;
        next_state.port_meta = port_in;
        next_state.port_sync = state.port_meta;
        next_state.shift_load = 1'b0;
        next_state.word = ROM_IMAGE[state.ptr];
        if (cmd_valid)
        begin
            next_state.ptr = ptr_inc;
            unique case (cmd_op)
                PDM_OP_NEXT:
                    next_state.ptr = ptr_inc;
                PDM_OP_JUMP, PDM_OP_CALL:
                    next_state.ptr = cmd_operand;
                PDM_OP_RETURN:
                    next_state.ptr = stack_top;
                PDM_OP_PAGE_JUMP, PDM_OP_PAGE_CALL:
                    next_state.ptr = {ptr_inc[PTR_W-1:PAGE_LSB],
                                      cmd_operand[PAGE_LSB-1:0]};
                PDM_OP_INDIRECT_JUMP:
                    next_state.ptr = {ptr_inc[PTR_W-1:BLOCK_LSB],
                                      table_word};
                PDM_OP_TABLE_LOOKUP:
                    next_state.latch = table_word;
                PDM_OP_LOAD_M:
                    next_state.acc = cur_digit;
                PDM_OP_STORE_M:
                    next_state.ram[cur_addr] = state.acc;
                PDM_OP_EXCH_M:
                begin
                    next_state.acc = cur_digit;
                    next_state.ram[cur_addr] = state.acc;
                end
                PDM_OP_DIRECT_LOAD:
                    next_state.acc = direct_digit;
                PDM_OP_DIRECT_EXCH:
                begin
                    next_state.acc = direct_digit;
                    next_state.ram[direct_addr] = state.acc;
                end
                PDM_OP_LATCH_TO_M:
                    next_state.ram[cur_addr] = latch_nib;
                PDM_OP_M_TO_LATCH:
                    if (hi_sel)
                        next_state.latch[LATCH_W-1:NIB_W] = cur_digit;
                    else
                        next_state.latch[NIB_W-1:0] = cur_digit;
                PDM_OP_PORT_TO_M:
                    next_state.ram[cur_addr] = port_nib;
                PDM_OP_A_TO_ROW:
                    next_state.ram_row_field = state.acc[1:0];
                PDM_OP_A_TO_DIGIT:
                    next_state.digit_select_field = state.acc;
                PDM_OP_A_TO_LATCH:
                    if (hi_sel)
                        next_state.latch[LATCH_W-1:NIB_W] = state.acc;
                    else
                        next_state.latch[NIB_W-1:0] = state.acc;
                PDM_OP_LATCH_TO_A:
                    next_state.acc = latch_nib;
                PDM_OP_PORT_TO_A:
                    next_state.acc = port_nib;
                PDM_OP_EXCH_SHIFT:
                begin
                    // Shifter lives outside; it loads on the pulse
                    next_state.acc = shifter_in;
                    next_state.shift_word = state.acc;
                    next_state.shift_load = 1'b1;
                end
                default:
                    next_state.ptr = ptr_inc;
            endcase
        end
        next_state.digit_out = next_state.digit_select_field;
    end

    // ******************************************************************
    // State register
    // ******************************************************************
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            // RAM contents survive reset, as in the original device
            state.ptr <= PTR_RESET;
            state.word <= WORD_RESET;
            state.acc <= NIB_RESET;
            state.ram_row_field <= INDEX_RESET[ADDR_W-1:ROW_LSB];
            state.digit_select_field <= NIB_RESET;
            state.digit_out <= NIB_RESET;
            state.latch <= LATCH_RESET;
            state.shift_word <= NIB_RESET;
            state.shift_load <= 1'b0;
            state.port_meta <= LATCH_RESET;
            state.port_sync <= LATCH_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign instr_pointer = state.ptr;
    assign fetched_word = state.word;
    assign accumulator = state.acc;
    assign ram_index = {state.ram_row_field, state.digit_select_field};
    assign nibble_out = state.digit_out;
    assign latch_out = state.latch;
    assign shifter_out = state.shift_word;
    assign shifter_load = state.shift_load;

endmodule : pdm_core

`default_nettype wire

// [pdm_core_sva.sv]
/*
 * Port-level assertions for the memory addressing core.
 * Assumes one clock, core_clk, and a synchronous active-high rst.
 */
`timescale 1ns/1ps
`default_nettype none

module pdm_core_sva
    import pdm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire pdm_op_t cmd_op,
    input wire logic [PTR_W-1:0] cmd_operand,
    input wire logic [NIB_W-1:0] shifter_in,
    input wire logic [PTR_W-1:0] instr_pointer,
    input wire logic [NIB_W-1:0] accumulator,
    input wire logic [ADDR_W-1:0] ram_index,
    input wire logic [NIB_W-1:0] nibble_out,
    input wire logic [LATCH_W-1:0] latch_out,
    input wire logic [NIB_W-1:0] shifter_out,
    input wire logic shifter_load
);
    // ********************************
    // Helpers and properties
    // ********************************
    logic [PTR_W-1:0] nxt;
    logic [PTR_W-1:0] page_tgt;
    logic [ADDR_W-1:0] row_tgt;
    logic seq_op;
    assign nxt = instr_pointer + PTR_ONE;
    assign page_tgt = {nxt[9:6], cmd_operand[5:0]};
    assign row_tgt = {accumulator[1:0], ram_index[3:0]};
    assign seq_op = !(cmd_op inside {PDM_OP_JUMP, PDM_OP_CALL,
        PDM_OP_RETURN, PDM_OP_PAGE_JUMP, PDM_OP_PAGE_CALL,
        PDM_OP_INDIRECT_JUMP});

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence call_s;
        cmd_valid && cmd_op == PDM_OP_CALL;
    endsequence
    sequence ret_s;
        cmd_valid && cmd_op == PDM_OP_RETURN;
    endsequence

    reset_clear_a: assert property (disable iff (1'b0) rst |=>
        instr_pointer == PTR_RESET && accumulator == NIB_RESET &&
        ram_index == INDEX_RESET && latch_out == LATCH_RESET &&
        nibble_out == NIB_RESET && !shifter_load)
        else $error("state not cleared by reset");
    ptr_step_a: assert property (cmd_valid && seq_op |=>
        instr_pointer == $past(nxt)) else $error("pointer not advanced");
    jump_load_a: assert property (cmd_valid &&
        cmd_op inside {PDM_OP_JUMP, PDM_OP_CALL} |=>
        instr_pointer == $past(cmd_operand)) else $error("jump target");
    page_jump_a: assert property (cmd_valid &&
        cmd_op inside {PDM_OP_PAGE_JUMP, PDM_OP_PAGE_CALL} |=>
        instr_pointer == $past(page_tgt)) else $error("page target");
    call_return_a: assert property (call_s ##1 ret_s |=>
        instr_pointer == $past(nxt, 2)) else $error("return address");
    idle_hold_a: assert property (!cmd_valid |=>
        $stable(instr_pointer) && $stable(accumulator) &&
        $stable(ram_index) && $stable(latch_out) && !shifter_load)
        else $error("state moved while idle");
    digit_out_a: assert property (nibble_out == ram_index[3:0])
        else $error("nibble outputs differ from digit field");
    row_load_a: assert property (cmd_valid &&
        cmd_op == PDM_OP_A_TO_ROW |=> ram_index == $past(row_tgt))
        else $error("row field load");
    shift_exch_a: assert property (cmd_valid &&
        cmd_op == PDM_OP_EXCH_SHIFT |=> shifter_load &&
        shifter_out == $past(accumulator) &&
        accumulator == $past(shifter_in)) else $error("shifter exchange");
endmodule : pdm_core_sva

bind pdm_core pdm_core_sva u_pdm_core_sva (.core_clk, .rst, .cmd_valid,
    .cmd_op, .cmd_operand, .shifter_in, .instr_pointer, .accumulator,
    .ram_index, .nibble_out, .latch_out, .shifter_out, .shifter_load);

`default_nettype wire

// [pdm_core_tb.sv]
/*
 * Self-checking bench for pdm_core: a reference model steps on every rising
 * edge and all outputs are compared at the falling edge.
 * Assumes fetched_word follows the pointer on every non-reset edge.
 */
`timescale 1ns/1ps
`default_nettype none

module pdm_core_tb
    import pdm_pkg::*;
;
    typedef logic [WORD_W-1:0] pdm_rom_t [ROM_WORDS];
    function automatic pdm_rom_t make_rom();
        for (int i = 0; i < ROM_WORDS; i++)
            make_rom[i] = WORD_W'(i * 37 + 5);
    endfunction : make_rom
    localparam pdm_rom_t ROM = make_rom();

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    pdm_op_t cmd_op = PDM_OP_NEXT;
    logic [PTR_W-1:0] cmd_operand = '0;
    logic [LATCH_W-1:0] port_in = '0;
    logic [NIB_W-1:0] shifter_in = '0;
    logic [PTR_W-1:0] instr_pointer, m_ptr;
    logic [STACK_DEPTH-1:0][PTR_W-1:0] m_stk;
    logic [WORD_W-1:0] fetched_word, m_word;
    logic [NIB_W-1:0] accumulator, nibble_out, shifter_out, m_acc, m_sout;
    logic [NIB_W-1:0] m_ram [RAM_DIGITS];
    logic [ADDR_W-1:0] ram_index, m_idx;
    logic [LATCH_W-1:0] latch_out, m_lat, s1, s2;
    logic shifter_load, m_load, armed = 1'b0;
    integer seed = 62;
    int n_fail = 0;
    int checked = 0;

    initial forever #50 core_clk = ~core_clk;

    pdm_core #(.ROM_IMAGE(ROM)) u_pdm_core (.core_clk, .rst, .cmd_valid,
        .cmd_op, .cmd_operand, .port_in, .shifter_in, .instr_pointer,
        .fetched_word, .accumulator, .ram_index, .nibble_out, .latch_out,
        .shifter_out, .shifter_load);

    // ********************************
    // Reference model and checks
    // ********************************
    function automatic logic [NIB_W-1:0] nib(logic [7:0] v, logic hi);
        return hi ? v[7:4] : v[3:0];
    endfunction : nib

    task automatic model_step();
        logic [PTR_W-1:0] nx;
        logic [NIB_W-1:0] m;
        logic [WORD_W-1:0] rw;
        logic hi;
        logic [ADDR_W-1:0] da;
        nx = m_ptr + PTR_ONE;
        m = m_ram[m_idx];
        hi = cmd_operand[0];
        da = cmd_operand[5:0];
        rw = ROM[{nx[9:8], m_acc, m}];
        armed = 1'b1;
        m_load = 1'b0;
        m_word = rst ? WORD_RESET : ROM[m_ptr];
        if (rst)
        begin
            {m_ptr, m_acc, m_idx, m_lat, m_sout} = '0;
            m_stk = '0;
        end
        else if (cmd_valid)
        begin
            m_ptr = nx;
            case (cmd_op)
                PDM_OP_JUMP: m_ptr = cmd_operand;
                PDM_OP_CALL:
                begin
                    m_ptr = cmd_operand;
                    m_stk = {m_stk[1:0], nx};
                end
                PDM_OP_RETURN:
                begin
                    // Bottom entry is kept, not cleared, on a pop
                    m_ptr = m_stk[0];
                    m_stk = {m_stk[2], m_stk[2:1]};
                end
                PDM_OP_PAGE_JUMP: m_ptr = {nx[9:6], da};
                PDM_OP_PAGE_CALL:
                begin
                    m_ptr = {nx[9:6], da};
                    m_stk = {m_stk[1:0], nx};
                end
                PDM_OP_INDIRECT_JUMP: m_ptr = {nx[9:8], rw};
                PDM_OP_TABLE_LOOKUP: m_lat = rw;
                PDM_OP_LOAD_M: m_acc = m;
                PDM_OP_STORE_M: m_ram[m_idx] = m_acc;
                PDM_OP_EXCH_M: {m_ram[m_idx], m_acc} = {m_acc, m};
                PDM_OP_DIRECT_LOAD: m_acc = m_ram[da];
                PDM_OP_DIRECT_EXCH: {m_ram[da], m_acc} = {m_acc, m_ram[da]};
                PDM_OP_LATCH_TO_M: m_ram[m_idx] = nib(m_lat, hi);
                PDM_OP_M_TO_LATCH: m_lat[hi*4+:4] = m;
                PDM_OP_PORT_TO_M: m_ram[m_idx] = nib(s2, hi);
                PDM_OP_A_TO_ROW: m_idx[5:4] = m_acc[1:0];
                PDM_OP_A_TO_DIGIT: m_idx[3:0] = m_acc;
                PDM_OP_A_TO_LATCH: m_lat[hi*4+:4] = m_acc;
                PDM_OP_LATCH_TO_A: m_acc = nib(m_lat, hi);
                PDM_OP_PORT_TO_A: m_acc = nib(s2, hi);
                PDM_OP_EXCH_SHIFT: {m_sout, m_acc, m_load} = {m_acc, shifter_in, 1'b1};
                default: ;
            endcase
        end
        // Synchroniser flops are cleared by reset
        {s2, s1} = rst ? 16'h0000 : {s1, port_in};
    endtask : model_step

    task automatic check(string name, logic [9:0] exp, logic [9:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic check_bit(string name, logic exp, logic got);
        check(name, {9'h000, exp}, {9'h000, got});
    endtask : check_bit

    always @(negedge core_clk)
    begin
        if (armed)
        begin
            check("pointer", m_ptr, instr_pointer);
            check("word", m_word, fetched_word);
            check("acc", m_acc, accumulator);
            check("index", m_idx, ram_index);
            check("nibble", m_idx[3:0], nibble_out);
            check("latch", m_lat, latch_out);
            check("shifter", m_sout, shifter_out);
            check_bit("load", m_load, shifter_load);
        end
    end

    // ********************************
    // Stimulus
    // ********************************
    task automatic issue(logic v, pdm_op_t op, logic [PTR_W-1:0] opnd);
        cmd_valid <= v;
        cmd_op <= op;
        cmd_operand <= opnd;
        shifter_in <= NIB_W'($random(seed));
        @(posedge core_clk);
        model_step();
    endtask : issue

    task automatic rand_run(int n);
        repeat (n)
        begin
            port_in <= LATCH_W'($random(seed));
            issue(|3'($random(seed)), pdm_op_t'(5'($random(seed))),
                PTR_W'($random(seed)));
        end
    endtask : rand_run

    task automatic summarize();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (6) issue(1'b0, PDM_OP_NEXT, '0);
        rst <= 1'b0;
        // Each digit gets the low four bits of its address as data, via the port path
        for (int a = 0; a < RAM_DIGITS; a++)
        begin
            port_in <= {2'b00, 2'(a >> 4), 4'(a)};
            repeat (2) issue(1'b1, PDM_OP_NEXT, '0);
            issue(1'b1, PDM_OP_PORT_TO_A, 10'h001);
            issue(1'b1, PDM_OP_A_TO_ROW, '0);
            issue(1'b1, PDM_OP_PORT_TO_A, 10'h000);
            issue(1'b1, PDM_OP_A_TO_DIGIT, '0);
            issue(1'b1, PDM_OP_STORE_M, '0);
        end
        issue(1'b1, PDM_OP_JUMP, 10'h03F);
        issue(1'b1, PDM_OP_PAGE_JUMP, 10'h015);
        issue(1'b1, PDM_OP_JUMP, 10'h0FF);
        issue(1'b1, PDM_OP_INDIRECT_JUMP, '0);
        issue(1'b1, PDM_OP_JUMP, 10'h0FF);
        issue(1'b1, PDM_OP_TABLE_LOOKUP, '0);
        for (int i = 0; i < 4; i++)
            issue(1'b1, PDM_OP_CALL, PTR_W'(i * 200 + 7));
        repeat (5) issue(1'b1, PDM_OP_RETURN, '0);
        for (int i = 0; i < 32; i++)
            issue(1'b1, pdm_op_t'(i), PTR_W'(i * 33));
        rand_run(2000);
        rst <= 1'b1;
        repeat (3) issue(1'b1, PDM_OP_CALL, 10'h155);
        rst <= 1'b0;
        rand_run(300);
        summarize();
    end

    initial
    begin
        #1000000;
        n_fail++;
        summarize();
    end
endmodule : pdm_core_tb

`default_nettype wire
